// ---- design/atx_pkg.sv ----
// shared constants and carrier types of the accumulator transfer execution block
package atx_pkg;

    // instruction codes (10-bit words)
    localparam logic [9:0] OP_PU1  = 10'h22E;
    localparam logic [9:0] OP_PU2  = 10'h22F;
    localparam logic [9:0] OP_ADC1 = 10'h204;
    localparam logic [9:0] OP_RLD1 = 10'h23F;
    localparam logic [9:0] OP_IRQ1 = 10'h23B;
    localparam logic [9:0] OP_IRQ2 = 10'h23E;
    localparam logic [9:0] OP_TMR1 = 10'h20E;
    localparam logic [9:0] OP_TMR2 = 10'h20F;
    localparam logic [9:0] OP_TMR6 = 10'h213;
    localparam logic [9:0] OP_TYA  = 10'h00C;
    localparam logic [9:0] OP_WCHK = 10'h2A0;
    localparam logic [9:0] OP_WDIS = 10'h29C;
    // exchange family: upper six bits, immediate j in the low nibble
    localparam logic [5:0] OP_XAM_HI  = 6'h2D;
    localparam logic [5:0] OP_MEM_EXCHANGE_DEC_OP_HI = 6'h2F;
    localparam logic [5:0] OP_MEM_EXCHANGE_INC_OP_HI = 6'h2E;

    // y values that trigger a skip after a step
    localparam logic [3:0] Y_DEC_SKIP = 4'hF;
    localparam logic [3:0] Y_INC_SKIP = 4'h0;

    // register byte addresses
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_STAT = 8'h04;
    localparam logic [7:0] ADR_PU1  = 8'h08;
    localparam logic [7:0] ADR_PU2  = 8'h0C;
    localparam logic [7:0] ADR_ADC1 = 8'h10;
    localparam logic [7:0] ADR_RLD1 = 8'h14;
    localparam logic [7:0] ADR_IRQ1 = 8'h18;
    localparam logic [7:0] ADR_IRQ2 = 8'h1C;
    localparam logic [7:0] ADR_TMR1 = 8'h20;
    localparam logic [7:0] ADR_TMR2 = 8'h24;
    localparam logic [7:0] ADR_TMR6 = 8'h28;
    localparam logic [7:0] ADR_X    = 8'h2C;
    localparam logic [7:0] ADR_Y    = 8'h30;

    // field positions
    localparam int CTRL_REARM_BIT = 0;
    localparam int CTRL_EN_BIT    = 1;
    localparam int STAT_SKIP_BIT  = 0;
    localparam int STAT_WDF_BIT   = 1;
    localparam int STAT_STOP_BIT  = 2;

    // reset values
    localparam logic [3:0] RST_NIB     = 4'h0;
    localparam logic [7:0] RST_BYTE    = 8'h00;
    localparam logic       RST_EXEC_EN = 1'b1;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } atx_wb_req_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } atx_wb_rsp_t;

    typedef struct packed {
        logic       valid;
        logic [9:0] code;
    } atx_instr_t;

    typedef struct packed {
        logic [3:0] pullup_one;
        logic [3:0] pullup_two;
        logic [3:0] adc_one;
        logic [7:0] reload_one;
        logic [3:0] irq_one;
        logic [3:0] irq_two;
        logic [3:0] timer_one;
        logic [3:0] timer_two;
        logic [3:0] timer_six;
    } atx_periph_t;

endpackage

// ---- design/atx_ld_reg.sv ----
// loadable control register of parameterised width
`timescale 1ns/100ps
`default_nettype none
module atx_ld_reg #(
    parameter int           W  = 4,
    parameter logic [W-1:0] RV = '0
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         we_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q_o <= RV;
        end else if (we_i) begin
            q_o <= d_i;
        end
    end
endmodule
`default_nettype wire

// ---- design/atx_y_step.sv ----
// y register stepper with wrap detection for the exchange-and-step ops
`timescale 1ns/100ps
`default_nettype none
module atx_y_step
    import atx_pkg::*;
(
    input  wire logic       dec_i,
    input  wire logic [3:0] y_i,
    output logic      [3:0] y_o,
    output logic            wrap_o
);
    // modulo-16 step; wrap flags the boundary value after the step
    assign y_o    = dec_i ? 4'(y_i - 4'h1) : 4'(y_i + 4'h1);
    assign wrap_o = dec_i ? (y_o == Y_DEC_SKIP) : (y_o == Y_INC_SKIP);
endmodule
`default_nettype wire

// ---- design/atx_exec.sv ----
// execution unit for accumulator transfers, watchdog check and ram exchanges
//
// Design decisions made here: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - pullup load one copies accumulator
// - pullup load two copies accumulator
// - adc control load copies accumulator
// - reload load takes B high, A low
// - irq control one load copies accumulator
// - irq control two load copies accumulator
// - timer control one load copies accumulator
// - timer control two load copies accumulator
// - accumulator copied into Y, no skip
// - watchdog check skips and clears set flag
// - clear flag means no skip, unchanged
// - disable then check stops watchdog
// - exchange A with ram, X xor j
// - exchange, decrement Y, skip at 15
// - exchange, increment Y, skip at 0
module atx_exec
    import atx_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire atx_wb_req_t wb_req_i,
    output atx_wb_rsp_t      wb_rsp_o,
    input  wire atx_instr_t  instr_i,
    input  wire logic [3:0]  acc_i,
    input  wire logic [3:0]  regb_i,
    input  wire logic [3:0]  ram_rdata_i,
    input  wire logic        wdt_flag_set_i,
    output atx_periph_t      periph_o,
    output logic [3:0]       x_o,
    output logic [3:0]       y_o,
    output logic             acc_wr_o,
    output logic [3:0]       acc_wdata_o,
    output logic             ram_we_o,
    output logic [3:0]       ram_wdata_o,
    output logic             skip_o,
    output logic             watchdog_flag_one_o,
    output logic             wdt_stop_o
);
    logic        skip_reg;
    logic        skip_next;
    logic        watchdog_flag_one_reg;
    logic        watchdog_flag_one_next;
    logic        dis_prev_reg;
    logic        dis_prev_next;
    logic        wdt_stop_reg;
    logic        wdt_stop_next;
    logic        exec_en_reg;
    logic [3:0]  x_reg;
    logic [3:0]  x_next;
    logic [3:0]  y_reg;
    logic [3:0]  y_next;
    logic        acc_wr_reg;
    logic [3:0]  acc_wdata_reg;
    logic        ram_we_reg;
    logic [3:0]  ram_wdata_reg;
    logic        ack_reg;
    logic [31:0] rdat_reg;
    logic [3:0]  y_step;
    logic        y_wrap;

    // skip pending: the fetched word still takes its cycle but does nothing
    // suppress skipped word
    wire logic live = instr_i.valid & exec_en_reg & ~skip_reg;

    wire logic [9:0] op = instr_i.code;
    wire logic [3:0] imm_j = op[3:0];
    wire logic dec_pu1  = live & (op == OP_PU1);
    wire logic dec_pu2  = live & (op == OP_PU2);
    wire logic dec_adc1 = live & (op == OP_ADC1);
    wire logic dec_rld1 = live & (op == OP_RLD1);
    wire logic dec_irq1 = live & (op == OP_IRQ1);
    wire logic dec_irq2 = live & (op == OP_IRQ2);
    wire logic dec_tmr1 = live & (op == OP_TMR1);
    wire logic dec_tmr2 = live & (op == OP_TMR2);
    wire logic dec_tmr6 = live & (op == OP_TMR6);
    wire logic dec_tya  = live & (op == OP_TYA);
    wire logic dec_wchk = live & (op == OP_WCHK);
    wire logic dec_wdis = live & (op == OP_WDIS);
    wire logic dec_xam  = live & (op[9:4] == OP_XAM_HI);
    wire logic dec_mem_exchange_dec_op = live & (op[9:4] == OP_MEM_EXCHANGE_DEC_OP_HI);
    wire logic dec_mem_exchange_inc_op = live & (op[9:4] == OP_MEM_EXCHANGE_INC_OP_HI);
    wire logic dec_xany = dec_xam | dec_mem_exchange_dec_op | dec_mem_exchange_inc_op;

    // loads never touch carry: this unit has no carry path at all
    // load pullup one
    atx_ld_reg #(.W(4), .RV(RST_NIB)) u_pu1 (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .we_i  (dec_pu1),
        .d_i   (acc_i),
        .q_o   (periph_o.pullup_one)
    );
    atx_ld_reg #(.W(4), .RV(RST_NIB)) u_pu2 (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .we_i  (dec_pu2),
        .d_i   (acc_i),
        .q_o   (periph_o.pullup_two)
    );
    atx_ld_reg #(.W(4), .RV(RST_NIB)) u_adc1 (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .we_i  (dec_adc1),
        .d_i   (acc_i),
        .q_o   (periph_o.adc_one)
    );
    atx_ld_reg #(.W(8), .RV(RST_BYTE)) u_rld1 (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .we_i  (dec_rld1),
        .d_i   ({regb_i, acc_i}),
        .q_o   (periph_o.reload_one)
    );
    atx_ld_reg #(.W(4), .RV(RST_NIB)) u_irq1 (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .we_i  (dec_irq1),
        .d_i   (acc_i),
        .q_o   (periph_o.irq_one)
    );
    atx_ld_reg #(.W(4), .RV(RST_NIB)) u_irq2 (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .we_i  (dec_irq2),
        .d_i   (acc_i),
        .q_o   (periph_o.irq_two)
    );
    atx_ld_reg #(.W(4), .RV(RST_NIB)) u_tmr1 (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .we_i  (dec_tmr1),
        .d_i   (acc_i),
        .q_o   (periph_o.timer_one)
    );
    atx_ld_reg #(.W(4), .RV(RST_NIB)) u_tmr2 (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .we_i  (dec_tmr2),
        .d_i   (acc_i),
        .q_o   (periph_o.timer_two)
    );
    atx_ld_reg #(.W(4), .RV(RST_NIB)) u_tmr6 (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .we_i  (dec_tmr6),
        .d_i   (acc_i),
        .q_o   (periph_o.timer_six)
    );

    atx_y_step u_ystep (
        .dec_i  (dec_mem_exchange_dec_op),
        .y_i    (y_reg),
        .y_o    (y_step),
        .wrap_o (y_wrap)
    );

    assign x_next = dec_xany ? (x_reg ^ imm_j) : x_reg;
    assign y_next = dec_tya ? acc_i : ((dec_mem_exchange_dec_op | dec_mem_exchange_inc_op) ? y_step : y_reg);

    // a valid word while skip is pending consumes the skip
    // step skip
    assign skip_next = instr_i.valid
                     ? (((dec_mem_exchange_dec_op | dec_mem_exchange_inc_op) & y_wrap) | (dec_wchk & watchdog_flag_one_reg))
                     : skip_reg;

    // set from the watchdog wins over the clear by the check op
    // clear after skip
    assign watchdog_flag_one_next = wdt_flag_set_i | (watchdog_flag_one_reg & ~dec_wchk);

    // only the very next instruction word may complete the stop sequence
    assign dis_prev_next = instr_i.valid ? dec_wdis : dis_prev_reg;

    // bus decode
    wire logic bus_req = wb_req_i.cyc & wb_req_i.stb & ~ack_reg;
    // writes land on the ack edge, where the master completes the cycle
    wire logic bus_fin = wb_req_i.cyc & wb_req_i.stb & ack_reg;
    wire logic ctrl_wr = bus_fin & wb_req_i.we & wb_req_i.sel[0] &
                         (wb_req_i.adr == ADR_CTRL);
    wire logic rearm   = ctrl_wr & wb_req_i.dat[CTRL_REARM_BIT];

    assign wdt_stop_next = (dec_wchk & dis_prev_reg) | (wdt_stop_reg & ~rearm);

    wire logic [31:0] ctrl_rd = {30'h0000_0000, exec_en_reg, 1'b0};
    wire logic [31:0] stat_rd = {29'h0000_0000, wdt_stop_reg, watchdog_flag_one_reg, skip_reg};
    wire logic [7:0]  adr = wb_req_i.adr;
    // unmapped and reserved locations read as zero
    wire logic [31:0] rd_mux =
        (adr == ADR_CTRL) ? ctrl_rd :
        (adr == ADR_STAT) ? stat_rd :
        (adr == ADR_PU1)  ? {28'h0000000, periph_o.pullup_one} :
        (adr == ADR_PU2)  ? {28'h0000000, periph_o.pullup_two} :
        (adr == ADR_ADC1) ? {28'h0000000, periph_o.adc_one} :
        (adr == ADR_RLD1) ? {24'h000000, periph_o.reload_one} :
        (adr == ADR_IRQ1) ? {28'h0000000, periph_o.irq_one} :
        (adr == ADR_IRQ2) ? {28'h0000000, periph_o.irq_two} :
        (adr == ADR_TMR1) ? {28'h0000000, periph_o.timer_one} :
        (adr == ADR_TMR2) ? {28'h0000000, periph_o.timer_two} :
        (adr == ADR_TMR6) ? {28'h0000000, periph_o.timer_six} :
        (adr == ADR_X)    ? {28'h0000000, x_reg} :
        (adr == ADR_Y)    ? {28'h0000000, y_reg} :
                            32'h0000_0000;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            skip_reg     <= 1'b0;
            watchdog_flag_one_reg     <= 1'b0;
            dis_prev_reg <= 1'b0;
            wdt_stop_reg <= 1'b0;
            x_reg        <= RST_NIB;
            y_reg        <= RST_NIB;
        end else begin
            skip_reg     <= skip_next;
            watchdog_flag_one_reg     <= watchdog_flag_one_next;
            dis_prev_reg <= dis_prev_next;
            wdt_stop_reg <= wdt_stop_next;
            x_reg        <= x_next;
            y_reg        <= y_next;
        end
    end

    // write-back strobes are registered, one cycle after the word
    // exchange write-back
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            acc_wr_reg    <= 1'b0;
            acc_wdata_reg <= RST_NIB;
            ram_we_reg    <= 1'b0;
            ram_wdata_reg <= RST_NIB;
        end else begin
            acc_wr_reg    <= dec_xany;
            acc_wdata_reg <= dec_xany ? ram_rdata_i : acc_wdata_reg;
            ram_we_reg    <= dec_xany;
            ram_wdata_reg <= dec_xany ? acc_i : ram_wdata_reg;
        end
    end

    // bus slave: ack one cycle after the request, dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg     <= 1'b0;
            rdat_reg    <= 32'h0000_0000;
            exec_en_reg <= RST_EXEC_EN;
        end else begin
            ack_reg     <= bus_req;
            rdat_reg    <= (bus_req & ~wb_req_i.we) ? rd_mux : rdat_reg;
            exec_en_reg <= ctrl_wr ? wb_req_i.dat[CTRL_EN_BIT] : exec_en_reg;
        end
    end

    assign wb_rsp_o.ack        = ack_reg;
    assign wb_rsp_o.dat        = rdat_reg;
    assign x_o                 = x_reg;
    assign y_o                 = y_reg;
    assign acc_wr_o            = acc_wr_reg;
    assign acc_wdata_o         = acc_wdata_reg;
    assign ram_we_o            = ram_we_reg;
    assign ram_wdata_o         = ram_wdata_reg;
    assign skip_o              = skip_reg;
    assign watchdog_flag_one_o = watchdog_flag_one_reg;
    assign wdt_stop_o          = wdt_stop_reg;

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence dis_then_chk_s;
        dec_wdis ##1 (dec_wchk & ~rearm);
    endsequence
    sequence skipped_word_s;
        skip_o ##0 instr_i.valid;
    endsequence

    pullup_one_a: assert property (
        dec_pu1 |=> periph_o.pullup_one == $past(acc_i) && !skip_o)
        else $error("pullup one not loaded");
    pullup_two_a: assert property (
        dec_pu2 |=> periph_o.pullup_two == $past(acc_i) && !skip_o)
        else $error("pullup two not loaded");
    adc_ctrl_a: assert property (
        dec_adc1 |=> periph_o.adc_one == $past(acc_i))
        else $error("adc control not loaded");
    reload_pair_a: assert property (
        dec_rld1 |=> periph_o.reload_one == {$past(regb_i), $past(acc_i)})
        else $error("reload byte wrong");
    irq_one_a: assert property (
        dec_irq1 |=> periph_o.irq_one == $past(acc_i))
        else $error("irq one not loaded");
    irq_two_a: assert property (
        dec_irq2 |=> periph_o.irq_two == $past(acc_i))
        else $error("irq two not loaded");
    timer_one_a: assert property (
        dec_tmr1 |=> periph_o.timer_one == $past(acc_i))
        else $error("timer one not loaded");
    timer_two_a: assert property (
        dec_tmr2 |=> periph_o.timer_two == $past(acc_i))
        else $error("timer two not loaded");
    timer_six_a: assert property (
        instr_i.valid && instr_i.code == 10'h213 && exec_en_reg && !skip_o
        |=> periph_o.timer_six == $past(acc_i) && !skip_o)
        else $error("timer six not loaded");
    y_transfer_a: assert property (
        dec_tya |=> y_o == $past(acc_i) && !skip_o)
        else $error("y transfer wrong");
    wdog_skip_a: assert property (
        dec_wchk && watchdog_flag_one_o && !wdt_flag_set_i
        |=> skip_o && !watchdog_flag_one_o)
        else $error("watchdog check skip or clear missing");
    wdog_noskip_a: assert property (
        dec_wchk && !watchdog_flag_one_o |=> !skip_o)
        else $error("watchdog check skipped on clear flag");
    wdog_stop_a: assert property (
        dis_then_chk_s |=> wdt_stop_o)
        else $error("watchdog not stopped");
    exchange_a: assert property (
        dec_xam |=> acc_wr_o && ram_we_o && acc_wdata_o == $past(ram_rdata_i)
            && ram_wdata_o == $past(acc_i) && x_o == ($past(x_o) ^ $past(instr_i.code[3:0]))
            && y_o == $past(y_o) && !skip_o)
        else $error("exchange wrong");
    exch_dec_a: assert property (
        dec_mem_exchange_dec_op |=> y_o == 4'($past(y_o) - 4'h1) && skip_o == (y_o == 4'hF))
        else $error("exchange decrement wrong");
    exch_inc_a: assert property (
        dec_mem_exchange_inc_op |=> y_o == 4'($past(y_o) + 4'h1) && skip_o == (y_o == 4'h0))
        else $error("exchange increment wrong");
    skip_nop_a: assert property (
        skipped_word_s |=> !acc_wr_o && !ram_we_o && !skip_o
            && $stable(x_o) && $stable(y_o) && $stable(periph_o))
        else $error("skipped word had an effect");

endmodule
`default_nettype wire

// ---- testbench/atx_exec_tb_top.sv ----
// self-checking bench for the accumulator transfer execution unit
`timescale 1ns/100ps
`default_nettype none
module atx_exec_tb_top
    import atx_pkg::*;
;
    logic        clk_i          = 1'b0;
    logic        rst_i          = 1'b1;
    atx_wb_req_t wb_req_i       = '0;
    atx_wb_rsp_t wb_rsp_o;
    atx_instr_t  instr_i        = '0;
    logic [3:0]  acc_i          = 4'h0;
    logic [3:0]  regb_i         = 4'h0;
    logic [3:0]  ram_rdata_i    = 4'h0;
    logic        wdt_flag_set_i = 1'b0;
    atx_periph_t periph_o;
    logic [3:0]  x_o;
    logic [3:0]  y_o;
    logic        acc_wr_o;
    logic [3:0]  acc_wdata_o;
    logic        ram_we_o;
    logic [3:0]  ram_wdata_o;
    logic        skip_o;
    logic        watchdog_flag_one_o;
    logic        wdt_stop_o;
    int          n_mismatch     = 0;
    int          checks_done    = 0;
    logic [31:0] rd;

    // strobes, skip, write data and X/Y packed for one compare
    wire logic [31:0] sx = {12'h000, y_o, acc_wr_o, ram_we_o, skip_o, 1'b0,
                            acc_wdata_o, ram_wdata_o, x_o};
    wire logic [11:0] sk = {y_o, acc_wr_o, ram_we_o, skip_o, 1'b0, x_o};

    logic [9:0] ld_code [9] = '{OP_PU1, OP_PU2, OP_ADC1, OP_RLD1, OP_IRQ1,
                                OP_IRQ2, OP_TMR1, OP_TMR2, OP_TMR6};
    logic [7:0] ld_adr [9]  = '{ADR_PU1, ADR_PU2, ADR_ADC1, ADR_RLD1, ADR_IRQ1,
                                ADR_IRQ2, ADR_TMR1, ADR_TMR2, ADR_TMR6};

    atx_exec i_dut (
        .clk_i               (clk_i),
        .rst_i               (rst_i),
        .wb_req_i            (wb_req_i),
        .wb_rsp_o            (wb_rsp_o),
        .instr_i             (instr_i),
        .acc_i               (acc_i),
        .regb_i              (regb_i),
        .ram_rdata_i         (ram_rdata_i),
        .wdt_flag_set_i      (wdt_flag_set_i),
        .periph_o            (periph_o),
        .x_o                 (x_o),
        .y_o                 (y_o),
        .acc_wr_o            (acc_wr_o),
        .acc_wdata_o         (acc_wdata_o),
        .ram_we_o            (ram_we_o),
        .ram_wdata_o         (ram_wdata_o),
        .skip_o              (skip_o),
        .watchdog_flag_one_o (watchdog_flag_one_o),
        .wdt_stop_o          (wdt_stop_o)
    );

    always #20 clk_i = ~clk_i;

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // one classic cycle; the wait is bounded so a dead slave ends the run
    task automatic wb_cycle(input logic we, input logic [7:0] adr,
                            input logic [31:0] wd, output logic [31:0] rdat);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_req_i <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: wd};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_rsp_o.ack !== 1'b1 && n < 16);
        rdat = wb_rsp_o.dat;
        wb_req_i <= '0;
        if (wb_rsp_o.ack !== 1'b1) begin
            n_mismatch++;
            complete_run();
        end
        @(posedge clk_i);
    endtask

    task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
        wb_cycle(1'b0, adr, 32'h0000_0000, rd);
        chk(rd, exp);
    endtask

    task automatic wr(input logic [7:0] adr, input logic [31:0] d);
        wb_cycle(1'b1, adr, d, rd);
    endtask

    // valid stays high so a following call is back to back
    task automatic run_op(input logic [9:0] code, input logic [3:0] a,
                          input logic [3:0] b, input logic [3:0] m);
        instr_i <= '{valid: 1'b1, code: code};
        acc_i <= a;
        regb_i <= b;
        ram_rdata_i <= m;
        @(posedge clk_i);
        #1;
    endtask

    task automatic idle();
        instr_i.valid <= 1'b0;
        @(posedge clk_i);
        #1;
    endtask

    function automatic logic [7:0] pfield(input int i);
        case (i)
            0: return {4'h0, periph_o.pullup_one};
            1: return {4'h0, periph_o.pullup_two};
            2: return {4'h0, periph_o.adc_one};
            3: return periph_o.reload_one;
            4: return {4'h0, periph_o.irq_one};
            5: return {4'h0, periph_o.irq_two};
            6: return {4'h0, periph_o.timer_one};
            7: return {4'h0, periph_o.timer_two};
            default: return {4'h0, periph_o.timer_six};
        endcase
    endfunction

    function automatic logic [31:0] ex(input logic [3:0] y, input logic [2:0] st,
                                       input logic [3:0] aw, input logic [3:0] rw,
                                       input logic [3:0] x);
        return {12'h000, y, st, 1'b0, aw, rw, x};
    endfunction

    initial begin
        logic [3:0] a;
        logic [3:0] b;
        logic [7:0] e;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        #1;
        chk(periph_o[39:8], 32'h0000_0000);
        chk(32'(periph_o[7:0]), 32'h0000_0000);
        chk(sx, 32'h0000_0000);
        rd_chk(ADR_CTRL, 32'h1 << CTRL_EN_BIT);
        rd_chk(ADR_STAT, 32'h0000_0000);
        rd_chk(8'hFC, 32'h0000_0000);
        for (int i = 0; i < 9; i++) begin
            a = 4'(i + 6);
            b = ~a;
            e = (i == 3) ? {b, a} : {4'h0, a};
            run_op(ld_code[i], a, b, 4'h0);
            chk(32'(pfield(i)), 32'(e));
            chk(32'({skip_o, acc_wr_o, ram_we_o}), 32'h0000_0000);
            idle();
            rd_chk(ld_adr[i], 32'(e));
        end
        run_op(OP_TYA, 4'hF, 4'h0, 4'h0);
        chk(sx, ex(4'hF, 3'b000, 4'h0, 4'h0, 4'h0));
        idle();
        run_op({OP_XAM_HI, 4'h5}, 4'h3, 4'h0, 4'hC);
        chk(sx, ex(4'hF, 3'b110, 4'hC, 4'h3, 4'h5));
        idle();
        run_op({OP_MEM_EXCHANGE_INC_OP_HI, 4'hA}, 4'h1, 4'h0, 4'h2);
        chk(sx, ex(4'h0, 3'b111, 4'h2, 4'h1, 4'hF));
        run_op({OP_XAM_HI, 4'h1}, 4'h4, 4'h0, 4'h6);
        chk(32'(sk), 32'(12'h00F));
        idle();
        run_op({OP_MEM_EXCHANGE_INC_OP_HI, 4'h0}, 4'h5, 4'h0, 4'h7);
        chk(sx, ex(4'h1, 3'b110, 4'h7, 4'h5, 4'hF));
        idle();
        run_op({OP_MEM_EXCHANGE_DEC_OP_HI, 4'h3}, 4'h8, 4'h0, 4'h9);
        chk(sx, ex(4'h0, 3'b110, 4'h9, 4'h8, 4'hC));
        run_op({OP_MEM_EXCHANGE_DEC_OP_HI, 4'hF}, 4'hA, 4'h0, 4'hB);
        chk(sx, ex(4'hF, 3'b111, 4'hB, 4'hA, 4'h3));
        run_op(OP_TYA, 4'h2, 4'h0, 4'h0);
        chk(32'(sk), 32'(12'hF03));
        idle();
        rd_chk(ADR_X, 32'h0000_0003);
        rd_chk(ADR_Y, 32'h0000_000F);
        // clear flag: no skip, following word executes
        run_op(OP_WCHK, 4'h0, 4'h0, 4'h0);
        chk(32'({skip_o, watchdog_flag_one_o}), 32'h0000_0000);
        run_op(OP_PU1, 4'hE, 4'h0, 4'h0);
        chk(32'(periph_o.pullup_one), 32'h0000_000E);
        idle();
        wdt_flag_set_i <= 1'b1;
        @(posedge clk_i);
        wdt_flag_set_i <= 1'b0;
        #1;
        chk(32'(watchdog_flag_one_o), 32'h0000_0001);
        run_op(OP_WCHK, 4'h0, 4'h0, 4'h0);
        chk(32'({skip_o, watchdog_flag_one_o}), 32'h0000_0002);
        run_op(OP_PU2, 4'hD, 4'h0, 4'h0);
        chk(32'({periph_o.pullup_two, skip_o}), 32'h0000_000E);
        idle();
        // a word between disable and check breaks the stop sequence
        run_op(OP_WDIS, 4'h0, 4'h0, 4'h0);
        run_op(OP_TYA, 4'h4, 4'h0, 4'h0);
        run_op(OP_WCHK, 4'h0, 4'h0, 4'h0);
        chk(32'(wdt_stop_o), 32'h0000_0000);
        // back to back: disable then check stops at once
        run_op(OP_WDIS, 4'h0, 4'h0, 4'h0);
        run_op(OP_WCHK, 4'h0, 4'h0, 4'h0);
        chk(32'(wdt_stop_o), 32'h0000_0001);
        idle();
        wr(ADR_CTRL, (32'h1 << CTRL_EN_BIT) | (32'h1 << CTRL_REARM_BIT));
        rd_chk(ADR_STAT, 32'h0000_0000);
        run_op(OP_WDIS, 4'h0, 4'h0, 4'h0);
        idle();
        run_op(OP_WCHK, 4'h0, 4'h0, 4'h0);
        chk(32'(wdt_stop_o), 32'h0000_0001);
        idle();
        rd_chk(ADR_STAT, 32'h1 << STAT_STOP_BIT);
        wr(ADR_CTRL, (32'h1 << CTRL_EN_BIT) | (32'h1 << CTRL_REARM_BIT));
        rd_chk(ADR_STAT, 32'h0000_0000);
        // execution disabled: word ignored; read-only target ignores writes
        wr(ADR_CTRL, 32'h0000_0000);
        rd_chk(ADR_CTRL, 32'h0000_0000);
        run_op(OP_PU1, 4'h1, 4'h0, 4'h0);
        idle();
        chk(32'(periph_o.pullup_one), 32'h0000_000E);
        wr(ADR_CTRL, 32'h1 << CTRL_EN_BIT);
        wr(ADR_PU1, 32'h0000_0005);
        rd_chk(ADR_PU1, 32'h0000_000E);
        // second reset in mid-run
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        #1;
        chk(periph_o[39:8], 32'h0000_0000);
        chk(32'(periph_o[7:0]), 32'h0000_0000);
        chk(sx, 32'h0000_0000);
        rd_chk(ADR_CTRL, 32'h1 << CTRL_EN_BIT);
        complete_run();
    end
endmodule
`default_nettype wire
